/* File: pld_mc_pkg.sv */
// Overview of operation
// - Power-up clears all macrocell registers to zero.
// - Registered pins read high after power-up.
// - Preload forces each register high or low.
// - Secured part refuses verify and preload.
// - Security lock acts immediately once set.
// - Sixty-four bit signature always readable.
// - Each macrocell has one of four uses.
// - Device runs in one of three modes.
// - Undriven inputs are seen as one.
// - Registered cells use common clock and enable.
// - Combinatorial cells outside simple mode: one enable, seven sum terms.
// - Complex mode outer cells have no feedback.
// - Simple mode centre cells always enabled outputs.
package pld_mc_pkg;
    typedef enum logic [2:0] {
        MODE_REG    = 3'b001,
        MODE_CPLX   = 3'b010,
        MODE_SIMPLE = 3'b100
    } mode_t;

    localparam logic [1:0] CFG_REG      = 2'h0;
    localparam logic [1:0] CFG_COMB_IO  = 2'h1;
    localparam logic [1:0] CFG_COMB_OUT = 2'h2;
    localparam logic [1:0] CFG_INPUT    = 2'h3;

    localparam int MC_N       = 8;
    localparam int MC_PT      = 8;
    localparam int CFG_W      = 2;
    localparam int MC_OUTER_A = 0;
    localparam int MC_OUTER_B = 7;
    localparam int MC_CTR_A   = 3;
    localparam int MC_CTR_B   = 4;

    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_MCFG    = 8'h04;
    localparam logic [7:0] A_PRELOAD = 8'h08;
    localparam logic [7:0] A_VERIFY  = 8'h0c;
    localparam logic [7:0] A_SIG_LO  = 8'h10;
    localparam logic [7:0] A_SIG_HI  = 8'h14;

    localparam int    CTRL_SEC_BIT = 3;
    localparam mode_t MODE_RST     = MODE_REG;

    localparam int         CLK_NS     = 5;
    localparam int         PR_MAX_NS  = 1000;
    localparam logic [7:0] PR_CYCLES  = 8'(PR_MAX_NS / CLK_NS);
endpackage

/* File: pld_macrocell_reset_security.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pld_macrocell_reset_security
    import pld_mc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Device pins
    input  wire logic        i_supply_ok,
    input  wire logic        i_clk_pin,
    input  wire logic        i_oe_pin_n,
    input  wire logic [1:0]  i_ctl_drv,
    input  wire logic [7:0]  i_in_pin,
    input  wire logic [7:0]  i_in_drv,
    input  wire logic [7:0]  i_io_pin,
    input  wire logic [7:0]  i_io_drv,
    output logic      [7:0]  o_io_out,
    output logic      [7:0]  o_io_oe,
    // Logic array
    input  wire logic [63:0] i_pterm,
    output logic      [17:0] o_array_in,
    output logic             o_por_busy
);
    localparam int SYNC_W = 37;

    logic [SYNC_W-1:0] sync1_q, sync2_q;
    logic              supply_s, clk_s, oe_n_s;
    logic [1:0]        ctl_drv_s;
    logic [7:0]        in_s, in_drv_s, io_s, io_drv_s;
    logic              clk_seen, oe_n_seen, clk_prev_q, clk_rise;
    logic [7:0]        in_seen, io_seen;
    logic [7:0]        por_cnt_q;
    logic              por_busy_q;
    logic              pready_q, pslverr_q, acc, done, wr;
    logic [31:0]       prdata_q, rdata;
    logic              err;
    logic              secure_q;
    mode_t             mode_q;
    logic [15:0]       mc_cfg_q;
    logic [63:0]       sig_q;
    logic [7:0]        mc_q, d_w, oe_w, out_w, fb_w, reg_mask, pt0_w, nin_mask;
    logic              preload_go;

    // Every pin crosses two flops first
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {i_supply_ok, i_clk_pin, i_oe_pin_n, i_ctl_drv,
                        i_in_pin, i_in_drv, i_io_pin, i_io_drv};
            sync2_q <= sync1_q;
        end
    end

    assign {supply_s, clk_s, oe_n_s, ctl_drv_s, in_s, in_drv_s, io_s, io_drv_s} = sync2_q;

    // Weak pull-ups lose to any driver
    assign clk_seen  = clk_s | ~ctl_drv_s[0];
    assign oe_n_seen = oe_n_s | ~ctl_drv_s[1];
    assign in_seen   = in_s | ~in_drv_s;
    assign io_seen   = io_s | ~io_drv_s;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            clk_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= clk_seen;
        end
    end

    assign clk_rise = clk_seen & ~clk_prev_q;

    // Power-up reset: held for the longest interval so late clocks are safe
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || !supply_s) begin
            por_cnt_q <= '0;
        end else if (por_cnt_q != PR_CYCLES) begin
            por_cnt_q <= por_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            por_busy_q <= 1'b1;
        end else begin
            por_busy_q <= !(supply_s && por_cnt_q == PR_CYCLES);
        end
    end

    assign o_por_busy = por_busy_q;

    // APB: one wait state so read data comes from flops
    assign acc  = i_psel & i_penable;
    assign done = acc & pready_q;
    assign wr   = done & i_pwrite;

    always_comb begin
        err   = 1'b0;
        rdata = '0;
        case (i_paddr)
            A_CTRL: begin
                rdata = {28'h0, secure_q, mode_q};
                err   = i_pwrite & secure_q;
            end
            A_MCFG: begin
                rdata = secure_q ? 32'h0 : {16'h0, mc_cfg_q};
                err   = secure_q;
            end
            A_PRELOAD: err = secure_q;
            A_VERIFY: begin
                rdata = secure_q ? 32'h0 : {24'h0, mc_q};
                err   = secure_q | i_pwrite;
            end
            A_SIG_LO: rdata = sig_q[31:0];
            A_SIG_HI: rdata = sig_q[63:32];
            default:  err = 1'b1;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q <= acc & ~pready_q;
            if (acc && !pready_q) begin
                pslverr_q <= err;
                prdata_q  <= i_pwrite ? 32'h0 : rdata;
            end
        end
    end

    assign o_pready  = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_prdata  = prdata_q;

    // Configuration; the fuse only clears on erase (reset)
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            secure_q <= 1'b0;
            mode_q   <= MODE_RST;
            mc_cfg_q <= '0;
            sig_q    <= '0;
        end else if (wr && !err) begin
            case (i_paddr)
                A_CTRL: begin
                    secure_q <= i_pwdata[CTRL_SEC_BIT];
                    if (i_pwdata[2:0] == MODE_REG || i_pwdata[2:0] == MODE_CPLX ||
                        i_pwdata[2:0] == MODE_SIMPLE) begin
                        mode_q <= mode_t'(i_pwdata[2:0]);
                    end
                end
                A_MCFG:   mc_cfg_q      <= i_pwdata[15:0];
                A_SIG_LO: sig_q[31:0]   <= i_pwdata;
                A_SIG_HI: sig_q[63:32]  <= i_pwdata;
                default: ;
            endcase
        end
    end

    assign preload_go = wr && i_paddr == A_PRELOAD && !secure_q;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst || por_busy_q) begin
            mc_q <= '0;
        end else if (preload_go) begin
            mc_q <= i_pwdata[7:0];
        end else if (clk_rise && mode_q == MODE_REG) begin
            mc_q <= d_w & reg_mask;
        end
    end

    for (genvar g = 0; g < MC_N; g++) begin : g_mc
        logic [MC_PT-1:0] pt;
        logic [1:0]       cfg;
        logic             c_oe, c_out, fb_ok, pin_val;

        assign pt      = i_pterm[g*MC_PT +: MC_PT];
        assign cfg     = mc_cfg_q[g*CFG_W +: CFG_W];
        assign pin_val = c_oe ? c_out : io_seen[g];

        always_comb begin
            c_oe  = 1'b0;
            c_out = 1'b0;
            fb_ok = (cfg != CFG_COMB_OUT);
            case (mode_q)
                MODE_REG: begin
                    if (cfg == CFG_REG) begin
                        c_oe  = ~oe_n_seen;
                        c_out = ~mc_q[g];
                    end else if (cfg != CFG_INPUT) begin
                        c_oe  = pt[0];
                        c_out = |pt[MC_PT-1:1];
                    end
                end
                MODE_CPLX: begin
                    if (cfg != CFG_INPUT || g == MC_OUTER_A || g == MC_OUTER_B) begin
                        c_oe  = pt[0];
                        c_out = |pt[MC_PT-1:1];
                    end
                    if (g == MC_OUTER_A || g == MC_OUTER_B) begin
                        fb_ok = 1'b0;
                    end
                end
                MODE_SIMPLE: begin
                    if (cfg != CFG_INPUT || g == MC_CTR_A || g == MC_CTR_B) begin
                        c_oe  = 1'b1;
                        c_out = |pt;
                    end
                    if (g == MC_CTR_A || g == MC_CTR_B) begin
                        fb_ok = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        assign reg_mask[g] = (mode_q == MODE_REG) && (cfg == CFG_REG);
        assign d_w[g]      = |pt;
        assign oe_w[g]     = c_oe;
        assign out_w[g]    = c_out;
        assign fb_w[g]     = reg_mask[g] ? mc_q[g] : (fb_ok & pin_val);
        assign pt0_w[g]    = pt[0];
        assign nin_mask[g] = (cfg != CFG_INPUT);
    end

    assign o_io_oe  = oe_w;
    assign o_io_out = out_w;
    // Clock and enable pins only reach the array outside registered mode
    assign o_array_in = {fb_w, in_seen,
                         (mode_q != MODE_REG) & oe_n_seen,
                         (mode_q != MODE_REG) & clk_seen};

    chk_por_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        por_busy_q |=> (mc_q == 8'h00))
        else $error("register not cleared by power-up reset");

    chk_out_high: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $fell(por_busy_q) |-> ((o_io_out | ~reg_mask) == 8'hff))
        else $error("registered output not high after reset");

    chk_preload_load: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        preload_go |=> (mc_q == $past(i_pwdata[7:0])))
        else $error("preload value not loaded");

    chk_secure_refuse: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (done && secure_q && (i_paddr == A_PRELOAD || i_paddr == A_VERIFY)) |-> o_pslverr)
        else $error("secured access not refused");

    chk_fuse_now: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (wr && i_paddr == A_CTRL && !secure_q && i_pwdata[CTRL_SEC_BIT]) |=> secure_q [*8])
        else $error("security lock not immediate");

    chk_sig_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (done && !i_pwrite && (i_paddr == A_SIG_LO || i_paddr == A_SIG_HI)) |-> !o_pslverr)
        else $error("signature read refused");

    chk_pullup_one: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        ((o_array_in[9:2] | in_drv_s) == 8'hff) && ((io_seen | io_drv_s) == 8'hff))
        else $error("undriven input not seen high");

    chk_reg_oe: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (((o_io_oe ^ {8{~oe_n_seen}}) & reg_mask) == 8'h00))
        else $error("registered cell enable not from common pin");

    chk_cplx_oe: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (mode_q == MODE_CPLX) |-> (((o_io_oe ^ pt0_w) & nin_mask) == 8'h00))
        else $error("complex cell enable not first product term");

    chk_outer_nofb: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (mode_q == MODE_CPLX) |-> (!fb_w[MC_OUTER_A] && !fb_w[MC_OUTER_B]))
        else $error("outer cell feedback in complex mode");

    chk_centre_on: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (mode_q == MODE_SIMPLE) |-> (o_io_oe[MC_CTR_A] && o_io_oe[MC_CTR_B]))
        else $error("centre cell not enabled in simple mode");

    chk_clk_capture: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (clk_rise && !por_busy_q && !preload_go && mode_q == MODE_REG)
        |=> (mc_q == $past(d_w & reg_mask)))
        else $error("register missed clock edge");

    chk_por_len: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $fell(por_busy_q) |-> (por_cnt_q == PR_CYCLES))
        else $error("power-up reset ended early");

    chk_verify_blank: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (done && secure_q && !i_pwrite && (i_paddr == A_VERIFY || i_paddr == A_MCFG))
        |-> (o_prdata == 32'h0))
        else $error("secured configuration read not blanked");

    chk_mode_onehot: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $onehot(mode_q))
        else $error("mode not exactly one of three");
endmodule // pld_macrocell_reset_security

/* File: pld_ext_logic.sv */
`timescale 1ns/1ps
module pld_ext_logic #(
    parameter int SETUP_CYC = 4
) (
    // Control
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    input  wire logic i_por_busy,
    input  wire logic i_fire,
    // Clock pin
    output logic      o_clk_pin,
    output logic      o_idle
);
    logic [1:0] st_q;
    logic [3:0] cnt_q;

    assign o_idle = (st_q == 2'h0);

    // Pin held low while power-up reset runs
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || i_por_busy) begin
            st_q      <= 2'h0;
            cnt_q     <= 4'h0;
            o_clk_pin <= 1'b0;
        end else begin
            case (st_q)
                2'h0: begin
                    cnt_q <= 4'h0;
                    if (i_fire) begin
                        st_q <= 2'h1;
                    end
                end
                2'h1: begin
                    cnt_q <= cnt_q + 4'h1;
                    // Inputs settle a full setup before the edge
                    if (cnt_q == 4'(SETUP_CYC)) begin
                        o_clk_pin <= 1'b1;
                        st_q      <= 2'h2;
                        cnt_q     <= 4'h0;
                    end
                end
                default: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(SETUP_CYC)) begin
                        o_clk_pin <= 1'b0;
                        st_q      <= 2'h0;
                    end
                end
            endcase
        end
    end
endmodule // pld_ext_logic

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import pld_mc_pkg::*;
    logic        i_mclk, i_nrst, i_psel, i_penable, i_pwrite, i_supply_ok;
    logic        i_clk_pin, i_oe_pin_n, fire, idle;
    logic [7:0]  i_paddr, i_in_pin, i_in_drv, i_io_pin, i_io_drv;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic        o_pready, o_pslverr, o_por_busy, e;
    logic [1:0]  i_ctl_drv;
    logic [63:0] i_pterm;
    logic [7:0]  o_io_out, o_io_oe;
    logic [17:0] o_array_in;
    int          err_total, n_tests, n;

    pld_macrocell_reset_security u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_supply_ok(i_supply_ok),
        .i_clk_pin(i_clk_pin), .i_oe_pin_n(i_oe_pin_n), .i_ctl_drv(i_ctl_drv), .i_in_pin(i_in_pin),
        .i_in_drv(i_in_drv), .i_io_pin(i_io_pin), .i_io_drv(i_io_drv), .o_io_out(o_io_out),
        .o_io_oe(o_io_oe), .i_pterm(i_pterm), .o_array_in(o_array_in), .o_por_busy(o_por_busy));
    pld_ext_logic u_ext (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_por_busy(o_por_busy), .i_fire(fire),
        .o_clk_pin(i_clk_pin), .o_idle(idle));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits for pready with a bound; never assumes the wait state count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_mclk);
        i_psel    <= 1'b1;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        i_penable <= 1'b0;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            k++;
        end while (o_pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_total++;
            finish_test();
        end
        rd = o_prdata;
        e  = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic clk_pulse();
        @(posedge i_mclk);
        fire <= 1'b1;
        @(posedge i_mclk);
        fire <= 1'b0;
        // Idle reads high before the model leaves idle, so see the pin rise first
        n = 0;
        while (i_clk_pin !== 1'b1 && n < 40) begin
            @(posedge i_mclk);
            n++;
        end
        while ((idle !== 1'b1 || i_clk_pin !== 1'b0) && n < 80) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 80) begin
            err_total++;
            finish_test();
        end
        repeat (4) @(posedge i_mclk);
    endtask

    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    initial begin
        err_total = 0; n_tests = 0; fire = 1'b0;
        i_nrst = 1'b0; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
        i_paddr = 8'h00; i_pwdata = 32'h0; i_supply_ok = 1'b0; i_oe_pin_n = 1'b0;
        i_ctl_drv = 2'h3; i_in_pin = 8'h00; i_in_drv = 8'h00; i_io_pin = 8'h00;
        i_io_drv = 8'h00; i_pterm = 64'h0;
        repeat (3) @(posedge i_mclk);
        i_nrst      <= 1'b1;
        i_supply_ok <= 1'b1;
        @(negedge i_mclk);
        chk(o_por_busy, 1'b1);
        chk(o_io_out, 8'hff);
        apb(1'b0, A_VERIFY, 32'h0);
        chk(rd, 32'h0);
        n = 0;
        while (o_por_busy !== 1'b0 && n < 300) begin
            @(posedge i_mclk);
            n++;
        end
        @(negedge i_mclk);
        chk(o_por_busy, 1'b0);
        chk(o_io_out, 8'hff);
        chk(o_array_in[9:2], 8'hff);
        chk(o_io_oe, 8'hff);
        // Pins pass two sync flops before the array sees them
        @(posedge i_mclk);
        i_in_drv <= 8'hff;
        i_in_pin <= 8'h3c;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        chk(o_array_in[9:2], 8'h3c);
        $display("test powerup done");

        apb(1'b1, A_PRELOAD, 32'ha5);
        apb(1'b0, A_VERIFY, 32'h0);
        chk(rd, 32'ha5);
        chk(o_io_out, 8'h5a);
        i_pterm <= 64'h0000_0000_8040_2001;
        clk_pulse();
        apb(1'b0, A_VERIFY, 32'h0);
        chk(rd, 32'h0f);
        chk(o_io_out, 8'hf0);
        $display("test preload done");

        apb(1'b1, A_MCFG, 32'h5555);
        apb(1'b1, A_CTRL, 32'h2);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd[2:0], 3'h2);
        i_pterm <= 64'h0000_0000_0002_0301;
        @(negedge i_mclk);
        chk(o_io_oe, 8'h03);
        chk(o_io_out & o_io_oe, 8'h02);
        apb(1'b1, A_CTRL, 32'h3);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd[2:0], 3'h2);
        // Simple mode, all cells inputs except the fixed centre pair
        apb(1'b1, A_MCFG, 32'hffff);
        apb(1'b1, A_CTRL, 32'h4);
        i_pterm <= 64'h0000_0000_8000_0000;
        @(negedge i_mclk);
        chk(o_io_oe, 8'h18);
        chk(o_io_out[4:3], 2'h1);
        apb(1'b1, A_MCFG, 32'h0);
        apb(1'b1, A_CTRL, 32'h1);
        @(negedge i_mclk);
        chk(o_io_oe, 8'hff);
        $display("test modes done");

        apb(1'b1, A_SIG_LO, 32'h1357_9bdf);
        apb(1'b1, A_SIG_HI, 32'h2468_ace0);
        apb(1'b1, A_CTRL, 32'h9);
        apb(1'b1, A_PRELOAD, 32'h33);
        chk(e, 1'b1);
        apb(1'b0, A_VERIFY, 32'h0);
        chk({e, rd}, 33'h1_0000_0000);
        chk(o_io_out, 8'hf0);
        apb(1'b0, A_SIG_LO, 32'h0);
        chk({e, rd}, 33'h0_1357_9bdf);
        apb(1'b1, A_SIG_HI, 32'h0f0f_0f0f);
        apb(1'b0, A_SIG_HI, 32'h0);
        chk({e, rd}, 33'h0_0f0f_0f0f);
        apb(1'b0, 8'h20, 32'h0);
        chk(e, 1'b1);
        $display("test security done");
        finish_test();
    end
endmodule // tb
